//--- design/spto_pkg.sv
// Purpose: Shared constants and types of the serial port timeout pair.
// Assumes: Counts are in sys_clk cycles, which is the master clock.
// Notes: Reload values absorb the pin synchroniser latency.
package spto_pkg;
  localparam int BYTE_W = 8;
  localparam int TMO_SHORT = 256;
  localparam int TMO_LONG = 4096;
  localparam int TMR_W = 13;
  // Cycles from a pin edge to the timer reload.
  localparam int TMO_LAT = 4;
  localparam logic [TMR_W-1:0] TMO_SHORT_LD = TMR_W'(TMO_SHORT - TMO_LAT);
  localparam logic [TMR_W-1:0] TMO_LONG_LD = TMR_W'(TMO_LONG - TMO_LAT);
  localparam logic [TMR_W-1:0] TMR_ONE = 13'h0001;
  // Reset value of the synchronisers: reset pin high, select high, clock low.
  localparam logic [2:0] SYNC_RST = 3'h6;
  localparam int HALF_DIV = 12;
  localparam int GAP_CYC = 16;
  localparam int RST_LEN = 4;
  localparam int FIFO_DEPTH = 2;
  localparam int DIV_W = 8;
  typedef enum logic [2:0] {
    SPTO_IDLE,
    SPTO_LOW,
    SPTO_HIGH,
    SPTO_NEXT,
    SPTO_TRAIL,
    SPTO_GAP,
    SPTO_PINRST
  } spto_hst_state_type;
endpackage : spto_pkg

//--- design/spto_link_if.sv
// Purpose: Pins between the serial controller and the target device.
// Assumes: All pins are driven one way only.
// Notes: The controller makes sclk; the device drives only miso.
`timescale 1ns/1ps
interface spto_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic rst_n_pin;
  modport dev
  (
    input cs_n,
    input sclk,
    input mosi,
    input rst_n_pin,
    output miso
  );
  modport ctl
  (
    output cs_n,
    output sclk,
    output mosi,
    output rst_n_pin,
    input miso
  );
endinterface : spto_link_if

//--- design/spto_dev.sv
// Purpose: Target end of a serial port with an inactivity timeout.
// Assumes: sys_clk is the master clock; link pins are asynchronous to it.
// Notes: Received bits are shifted on the link clock; framing, the
//   timer and the output shifter run on sys_clk.
// How it works
// - Port frames only while select is low.
// - One bit in and out per clock.
// - Idle clock for selected count resets port.
// - Select fall or clock edge reloads timer.
// - Timer expiry performs a port reset.
// - Timer stays disarmed until next reload event.
// - Timeout lands within two cycles of count.
// - Shorter gaps never cause a timeout.
// - Controller keeps edge gaps below timer value, except while it waits in SPTO_NEXT with select low.
// - Controller may space transfers around timeouts.
// - Controller toggles select around each transfer.
// - Reset pin low then high resets device.
`timescale 1ns/1ps
module spto_dev
#(
  parameter int BYTE_W = spto_pkg::BYTE_W
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tmo_long,
  input wire logic [BYTE_W-1:0] tx_data,
  output logic tx_load,
  output logic [BYTE_W-1:0] rx_data,
  output logic rx_valid,
  output logic port_active,
  output logic port_timeout,
  spto_link_if.dev link
);
  localparam int NSYNC = 3;
  localparam int BW = $clog2(BYTE_W);
  localparam logic [BW-1:0] LAST_BIT = BW'(BYTE_W - 1);

  logic [BYTE_W-1:0] link_shift_r;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] filt_r;
  logic [NSYNC-1:0] filt_nxt;
  logic [spto_pkg::TMR_W-1:0] tmr_r;
  logic armed_r;
  logic [BW-1:0] bit_cnt_r;
  logic [BYTE_W-1:0] tx_shift_r;
  logic tx_load_r;
  logic [BYTE_W-1:0] rx_data_r;
  logic rx_valid_r;
  logic port_active_r;
  logic port_timeout_r;

  // Only the receive shifter faces the link clock. Its contents stand
  // still from one rising edge to the next, so sys_clk may copy them
  // once the synchronised rising edge has been seen.
  always_ff @(posedge link.sclk)
  begin
    if (!link.cs_n)
    begin
      link_shift_r <= {link_shift_r[BYTE_W-2:0], link.mosi};
    end
  end

  assign pin_raw = {link.rst_n_pin, link.cs_n, link.sclk};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s1_r <= spto_pkg::SYNC_RST;
      s2_r <= spto_pkg::SYNC_RST;
      s3_r <= spto_pkg::SYNC_RST;
      filt_r <= spto_pkg::SYNC_RST;
    end
    else if (ce)
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // A pin change counts once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_filt
      assign filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
    end
  endgenerate

  wire [NSYNC-1:0] chg = filt_nxt ^ filt_r;
  wire sclk_edge = chg[0];
  wire sclk_rise = chg[0] & filt_nxt[0];
  wire sclk_fall = chg[0] & ~filt_nxt[0];
  wire cs_fall = chg[1] & ~filt_nxt[1];
  wire cs_rise = chg[1] & filt_nxt[1];
  wire in_frame = ~filt_r[1];
  wire dev_rst = rst | ~filt_r[2];

  wire reload = cs_fall | sclk_edge;
  wire [spto_pkg::TMR_W-1:0] reload_val = tmo_long ?
    spto_pkg::TMO_LONG_LD : spto_pkg::TMO_SHORT_LD;
  wire expire = armed_r & (tmr_r == spto_pkg::TMR_ONE) & ~reload;
  wire byte_done = in_frame & sclk_rise & (bit_cnt_r == LAST_BIT);
  wire tx_reload = cs_fall | expire |
    (in_frame & sclk_fall & (bit_cnt_r == '0));

  // The reload value is the count less the synchroniser latency, so the
  // pulse on port_timeout lands at the selected count after the pin edge.
  always_ff @(posedge sys_clk)
  begin
    if (dev_rst)
    begin
      tmr_r <= '0;
      armed_r <= 1'b0;
    end
    else if (ce)
    begin
      if (reload)
      begin
        tmr_r <= reload_val;
        armed_r <= 1'b1;
      end
      else if (expire)
      begin
        tmr_r <= '0;
        armed_r <= 1'b0;
      end
      else if (armed_r)
      begin
        tmr_r <= tmr_r - spto_pkg::TMR_ONE;
      end
    end
  end

  // Bit framing: a timeout or a rising select returns to bit zero.
  always_ff @(posedge sys_clk)
  begin
    if (dev_rst)
    begin
      bit_cnt_r <= '0;
    end
    else if (ce)
    begin
      if (expire | cs_rise | cs_fall)
      begin
        bit_cnt_r <= '0;
      end
      else if (in_frame & sclk_rise)
      begin
        bit_cnt_r <= byte_done ? '0 : bit_cnt_r + 1'b1;
      end
    end
  end

  // Output shifter: loads at frame start, after a timeout and on the
  // falling edge that closes a byte; otherwise shifts on each fall.
  always_ff @(posedge sys_clk)
  begin
    if (dev_rst)
    begin
      tx_shift_r <= '0;
      tx_load_r <= 1'b0;
    end
    else if (ce)
    begin
      tx_load_r <= tx_reload;
      if (tx_reload)
      begin
        tx_shift_r <= tx_data;
      end
      else if (in_frame & sclk_fall)
      begin
        tx_shift_r <= {tx_shift_r[BYTE_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (dev_rst)
    begin
      rx_data_r <= '0;
      rx_valid_r <= 1'b0;
      port_active_r <= 1'b0;
      port_timeout_r <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid_r <= byte_done;
      if (byte_done)
      begin
        rx_data_r <= link_shift_r;
      end
      port_active_r <= ~filt_nxt[1];
      port_timeout_r <= expire;
    end
  end

  assign link.miso = tx_shift_r[BYTE_W-1];
  assign tx_load = tx_load_r;
  assign rx_data = rx_data_r;
  assign rx_valid = rx_valid_r;
  assign port_active = port_active_r;
  assign port_timeout = port_timeout_r;
endmodule : spto_dev

//--- design/spto_ctl.sv
// Purpose: Controller end that frames bytes onto the serial link.
// Assumes: sclk is sys_clk divided down; miso is asynchronous.
// Notes: A two-entry buffer holds queued bytes; a pending received
//   byte stalls the start of the next one.
`timescale 1ns/1ps
module spto_ctl
#(
  parameter int BYTE_W = spto_pkg::BYTE_W,
  parameter int DEPTH = spto_pkg::FIFO_DEPTH,
  parameter int HALF_DIV = spto_pkg::HALF_DIV,
  parameter int GAP_CYC = spto_pkg::GAP_CYC,
  parameter int RST_LEN = spto_pkg::RST_LEN
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tx_valid,
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic [BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic pin_reset_req,
  output logic busy,
  spto_link_if.ctl link
);
  localparam int FW = BYTE_W + 1;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int DW = spto_pkg::DIV_W;
  localparam int BW = $clog2(BYTE_W);
  localparam logic [DW-1:0] HALF_LD = DW'(HALF_DIV - 1);
  localparam logic [DW-1:0] GAP_LD = DW'(GAP_CYC - 1);
  localparam logic [DW-1:0] RST_LD = DW'(RST_LEN - 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [FW-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic tx_ready_r;
  spto_pkg::spto_hst_state_type st_r;
  logic [DW-1:0] div_r;
  logic [BW-1:0] bit_r;
  logic [BYTE_W-1:0] sh_r;
  logic [BYTE_W-1:0] cap_r;
  logic last_r;
  logic cs_n_r;
  logic sclk_r;
  logic mosi_r;
  logic rst_n_pin_r;
  logic [BYTE_W-1:0] rx_data_r;
  logic rx_valid_r;
  logic busy_r;
  logic m1_r;
  logic m2_r;
  logic m3_r;
  logic mf_r;

  wire fifo_ne = (cnt_r != '0);
  wire [FW-1:0] head = mem_r[rp_r];
  wire can_start = fifo_ne & ~rx_valid_r;
  wire idle_go = (st_r == spto_pkg::SPTO_IDLE) & ~pin_reset_req;
  wire take = ce & can_start & (idle_go | (st_r == spto_pkg::SPTO_NEXT));
  wire push = ce & tx_valid & tx_ready_r;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
  wire half_done = (div_r == '0);
  wire mf_nxt = (m2_r == m3_r) ? m3_r : mf_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      tx_ready_r <= 1'b0;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_r[wp_r] <= {tx_last, tx_data};
        wp_r <= (wp_r == LAST_PTR) ? '0 : wp_r + 1'b1;
      end
      if (take)
      begin
        rp_r <= (rp_r == LAST_PTR) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      tx_ready_r <= (cnt_nxt != FULL_CNT);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      m1_r <= 1'b0;
      m2_r <= 1'b0;
      m3_r <= 1'b0;
      mf_r <= 1'b0;
    end
    else if (ce)
    begin
      m1_r <= link.miso;
      m2_r <= m1_r;
      m3_r <= m2_r;
      mf_r <= mf_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= spto_pkg::SPTO_IDLE;
      div_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      cap_r <= '0;
      last_r <= 1'b0;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
      rst_n_pin_r <= 1'b1;
      rx_data_r <= '0;
      rx_valid_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else if (ce)
    begin
      busy_r <= (st_r != spto_pkg::SPTO_IDLE) | take;
      if (rx_ready)
      begin
        rx_valid_r <= 1'b0;
      end
      if (take)
      begin
        sh_r <= head[BYTE_W-1:0];
        mosi_r <= head[BYTE_W-1];
        last_r <= head[BYTE_W];
        bit_r <= '0;
        div_r <= HALF_LD;
        cs_n_r <= 1'b0;
        st_r <= spto_pkg::SPTO_LOW;
      end
      else
      begin
        case (st_r)
          spto_pkg::SPTO_IDLE:
          begin
            if (pin_reset_req)
            begin
              rst_n_pin_r <= 1'b0;
              div_r <= RST_LD;
              st_r <= spto_pkg::SPTO_PINRST;
            end
          end
          spto_pkg::SPTO_LOW:
          begin
            div_r <= half_done ? HALF_LD : div_r - 1'b1;
            if (half_done)
            begin
              sclk_r <= 1'b1;
              cap_r <= {cap_r[BYTE_W-2:0], mf_nxt};
              st_r <= spto_pkg::SPTO_HIGH;
            end
          end
          spto_pkg::SPTO_HIGH:
          begin
            div_r <= half_done ? HALF_LD : div_r - 1'b1;
            if (half_done)
            begin
              sclk_r <= 1'b0;
              if (bit_r == BW'(BYTE_W - 1))
              begin
                rx_data_r <= cap_r;
                rx_valid_r <= 1'b1;
                st_r <= last_r ? spto_pkg::SPTO_TRAIL : spto_pkg::SPTO_NEXT;
              end
              else
              begin
                bit_r <= bit_r + 1'b1;
                sh_r <= {sh_r[BYTE_W-2:0], 1'b0};
                mosi_r <= sh_r[BYTE_W-2];
                st_r <= spto_pkg::SPTO_LOW;
              end
            end
          end
          spto_pkg::SPTO_NEXT:
          begin
            div_r <= HALF_LD;
          end
          spto_pkg::SPTO_TRAIL:
          begin
            div_r <= half_done ? GAP_LD : div_r - 1'b1;
            if (half_done)
            begin
              cs_n_r <= 1'b1;
              st_r <= spto_pkg::SPTO_GAP;
            end
          end
          spto_pkg::SPTO_GAP:
          begin
            div_r <= half_done ? '0 : div_r - 1'b1;
            if (half_done)
            begin
              st_r <= spto_pkg::SPTO_IDLE;
            end
          end
          spto_pkg::SPTO_PINRST:
          begin
            div_r <= half_done ? GAP_LD : div_r - 1'b1;
            if (half_done)
            begin
              rst_n_pin_r <= 1'b1;
              st_r <= spto_pkg::SPTO_GAP;
            end
          end
          default:
          begin
            st_r <= spto_pkg::SPTO_IDLE;
          end
        endcase
      end
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.mosi = mosi_r;
  assign link.rst_n_pin = rst_n_pin_r;
  assign tx_ready = tx_ready_r;
  assign rx_data = rx_data_r;
  assign rx_valid = rx_valid_r;
  assign busy = busy_r;
endmodule : spto_ctl

//--- sim/spto_assertions.sv
// Purpose: Pin checks on the link between controller and device.
// Assumes: Half period of 12 and pin reset pulse of 4 sys_clk cycles.
// Notes: Everything samples on sys_clk.
`timescale 1ns/1ps
module spto_assertions
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic rst_n_pin
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_sclk_frame;
    $changed(sclk) |-> !cs_n;
  endproperty
  a_sclk_frame: assert property (p_sclk_frame)
    else $error("sclk moved outside a frame");
  property p_sclk_half;
    $rose(sclk) |-> ##11 sclk ##1 !sclk;
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("sclk high phase wrong");
  property p_first_edge;
    $fell(cs_n) |-> ##[1:253] $rose(sclk);
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("first sclk edge late");
  property p_edge_gap;
    $changed(sclk) |-> ##[1:253] ($changed(sclk) || $rose(cs_n));
  endproperty
  a_edge_gap: assert property (p_edge_gap)
    else $error("sclk gap too long");
  property p_cs_gap;
    $rose(cs_n) |-> cs_n[*8] ##1 cs_n[*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select high too short");
  property p_pin_len;
    $fell(rst_n_pin) |-> !rst_n_pin[*4] ##1 rst_n_pin;
  endproperty
  a_pin_len: assert property (p_pin_len)
    else $error("reset pin pulse length wrong");
  property p_pin_idle;
    !rst_n_pin |-> cs_n && !sclk;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("reset pin pulsed in a frame");
  property p_mosi_hold;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi moved while sclk high");
  property p_miso_hold;
    sclk && $past(sclk) && !cs_n |-> $stable(miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso moved while sclk high");
endmodule : spto_assertions

//--- sim/spto_test.sv
// Purpose: Traffic over the pair and timeout cases on a second device.
// Assumes: sys_clk 25 MHz; the second device's pins come from this bench.
// Notes: Drivers queue expected bytes and timeouts; a monitor compares.
`timescale 1ns/1ps
module spi_port_inactivity_timeout_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic tmo_sel = 1'b1;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic rx_ready = 1'b0;
  logic pin_req = 1'b0;
  logic [7:0] dtx = 8'h00;
  logic [7:0] ctx = 8'h00;
  logic [7:0] d_rxd, c_rxd, last_ld;
  logic tx_ready, d_rxv, d_load, c_rxv, busy, to2, act2;
  logic [12:0] exp_d[$], exp_c[$], exp_t[$];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int last_edge = 0;
  int bc = 0;
  spto_link_if lnk();
  spto_link_if lnk2();
  spto_dev spto_dev_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .tmo_long(tmo_sel), .tx_data(dtx), .tx_load(d_load), .rx_data(d_rxd),
    .rx_valid(d_rxv), .port_active(), .port_timeout(), .link(lnk.dev));
  spto_dev spto_dev_inst2 (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .tmo_long(tmo_sel), .tx_data(8'h5a), .tx_load(), .rx_data(),
    .rx_valid(), .port_active(act2), .port_timeout(to2), .link(lnk2.dev));
  spto_ctl spto_ctl_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .tx_valid(tx_valid), .tx_data(ctx), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_data(c_rxd), .rx_valid(c_rxv),
    .rx_ready(rx_ready), .pin_reset_req(pin_req), .busy(busy),
    .link(lnk.ctl));
  spto_assertions spto_assertions_inst (.sys_clk(sys_clk), .rst(rst),
    .cs_n(lnk.cs_n), .sclk(lnk.sclk), .mosi(lnk.mosi), .miso(lnk.miso),
    .rst_n_pin(lnk.rst_n_pin));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(posedge sys_clk) #1 rx_ready = 1'($urandom);
  always @(posedge sys_clk)
    if (d_load === 1'b1)
    begin
      last_ld = dtx;
      #1 dtx = 8'($urandom);
    end
  // The byte the device sends is the one it loaded before the first rise.
  always @(posedge lnk.sclk or posedge lnk.cs_n)
    if (lnk.cs_n)
      bc = 0;
    else
    begin
      if (bc == 0) exp_c.push_back({5'h00, last_ld});
      bc = (bc + 1) % 8;
    end
  always @(posedge sys_clk)
  begin
    if (d_rxv === 1'b1)
      chk("dev_rx", exp_d.size() ? exp_d.pop_front() : 13'h1fff,
        {5'h00, d_rxd}, 0);
    if (c_rxv === 1'b1 && rx_ready)
      chk("ctl_rx", exp_c.size() ? exp_c.pop_front() : 13'h1fff,
        {5'h00, c_rxd}, 0);
    if (!rst && to2 !== 1'b0)
      chk("timeout", exp_t.size() ? exp_t.pop_front() : 13'h1fff,
        13'(cyc - last_edge), 2);
  end
  task automatic chk(input string n, input logic [12:0] e,
    input logic [12:0] s, input int tol);
    checks_done++;
    if (tol == 0 ? s !== e : (s + tol < e || s > e + tol || $isunknown(s)))
    begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", n, e, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task push(input logic [7:0] d, input logic l);
    ctx = d;
    tx_last = l;
    tx_valid = 1'b1;
    @(posedge sys_clk);
    while (tx_ready !== 1'b1) @(posedge sys_clk);
    exp_d.push_back({5'h00, d});
    #1;
  endtask : push
  task frames(input int nf);
    int n;
    int i;
    for (int f = 0; f < nf; f++)
    begin
      n = 1 + $urandom_range(2);
      for (int k = 0; k < n; k++) push(8'($urandom), k == n - 1);
    end
    tx_valid = 1'b0;
    for (i = 0; i < 20000 && (exp_d.size() || exp_c.size() || busy); i++)
      tick(1);
    chk("drain", 13'h0, 13'(exp_d.size() + exp_c.size()), 0);
  endtask : frames
  task edge2(input logic c, input logic s, input logic [12:0] n);
    lnk2.cs_n = c;
    lnk2.sclk = s;
    lnk2.mosi = 1'($urandom);
    last_edge = cyc;
    if (n != 13'h0) exp_t.push_back(n);
  endtask : edge2
  task finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #2400000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'h80b92563));
    lnk2.cs_n = 1'b1;
    lnk2.sclk = 1'b0;
    lnk2.mosi = 1'b0;
    lnk2.rst_n_pin = 1'b1;
    tick(10);
    rst = 1'b0;
    tick(2);
    frames(6);
    pin_req = 1'b1;
    tick(1);
    pin_req = 1'b0;
    tick(20);
    frames(3);
    tmo_sel = 1'b0;
    edge2(1'b0, 1'b0, 13'd256);
    tick(10);
    chk("active", 13'h1, {12'h0, act2}, 0);
    tick(600);
    for (int i = 0; i < 4; i++)
    begin
      tick(200);
      edge2(1'b0, ~lnk2.sclk, i == 3 ? 13'd256 : 13'h0);
    end
    tick(300);
    // A pulse on the reset pin disarms the running timer.
    edge2(1'b0, ~lnk2.sclk, 13'h0);
    tick(50);
    lnk2.rst_n_pin = 1'b0;
    tick(8);
    chk("pin_active", 13'h0, {12'h0, act2}, 0);
    lnk2.rst_n_pin = 1'b1;
    tick(300);
    edge2(1'b1, lnk2.sclk, 13'h0);
    tick(20);
    chk("active", 13'h0, {12'h0, act2}, 0);
    // Holding ce low for 50 cycles delays the timeout by as many.
    edge2(1'b1, ~lnk2.sclk, 13'd306);
    tick(100);
    ce = 1'b0;
    tick(50);
    ce = 1'b1;
    tick(200);
    tmo_sel = 1'b1;
    edge2(1'b0, lnk2.sclk, 13'd4096);
    tick(4200);
    chk("tmo_left", 13'h0, 13'(exp_t.size()), 0);
    finish_test();
  end
endmodule : spi_port_inactivity_timeout_test
